/* File: bench/adc_serial_readout_oversampling_tb_top.sv */
// self-checking bench joining the host and converter ends over the link
`timescale 1ns/10ps
`default_nettype none
module adc_serial_readout_oversampling_tb_top import adcsr_pkg::*; ;
  localparam int SC = 20;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic conv = 1'b0;
  logic rd = 1'b0;
  logic dual_sel = 1'b0;
  logic use_b = 1'b0;
  logic per_ch = 1'b0;
  logic [OS_W-1:0] os_code = 3'h0;
  logic [NCH-1:0][RES-1:0] samp = '0;
  logic [OS_W-1:0] dev_os;
  logic dev_busy;
  logic [NCH-1:0][RES-1:0] h_result;
  logic h_valid;
  logic h_first;
  logic h_busy;
  logic h_reading;
  logic [RES-1:0] exp_r [NCH];
  int errors = 0;
  int checked = 0;
  int edges = 0;
  // --------------------------------------------------------------------
  // structure
  // --------------------------------------------------------------------
  adcsr_link_if adcsr_link_if_i ();
  adcsr_device #(.SAMPLE_CYCLES(SC)) adcsr_device_i (.lk(adcsr_link_if_i.dev),
    .i_clock(i_clock), .i_rst(i_rst), .i_channel_sample(samp), .o_os_applied(dev_os),
    .o_busy(dev_busy));
  adcsr_host #(.HALF(4)) adcsr_host_i (.lk(adcsr_link_if_i.host), .i_clock(i_clock),
    .i_rst(i_rst), .i_convert(conv), .i_os_code(os_code), .i_read(rd), .i_dual(dual_sel),
    .i_use_b(use_b), .i_cs_per_channel(per_ch), .o_busy(h_busy), .o_reading(h_reading),
    .o_result(h_result), .o_result_valid(h_valid), .o_first_seen(h_first));
  adcsr_properties #(.SAMPLE_CYCLES(SC)) adcsr_properties_i (.i_clock(i_clock),
    .i_rst(i_rst), .sclk(adcsr_link_if_i.sclk), .cs_n(adcsr_link_if_i.cs_n),
    .sel(adcsr_link_if_i.sel), .ss_a(adcsr_link_if_i.ss_a), .ss_b(adcsr_link_if_i.ss_b),
    .os(adcsr_link_if_i.os), .busy(adcsr_link_if_i.busy),
    .dout_a_o(adcsr_link_if_i.dout_a_o), .dout_a_oe(adcsr_link_if_i.dout_a_oe),
    .dout_b_o(adcsr_link_if_i.dout_b_o), .dout_b_oe(adcsr_link_if_i.dout_b_oe),
    .frst_o(adcsr_link_if_i.frst_o), .frst_oe(adcsr_link_if_i.frst_oe));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge adcsr_link_if_i.sclk) begin
    if (adcsr_link_if_i.cs_n === 1'b0) edges++;
  end
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic set_samples(input logic [RES-1:0] base);
    for (int c = 0; c < NCH; c++) samp[c] = base ^ (18'(c) * 18'h04321);
  endtask : set_samples
  task automatic pulse_convert;
    @(negedge i_clock);
    conv = 1'b1;
    @(negedge i_clock);
    conv = 1'b0;
  endtask : pulse_convert
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (dev_busy !== lvl && n < 3000) begin
      @(negedge i_clock);
      n++;
    end
  endtask : wait_busy
  // conversion with ratio code set; prev is the code latched before
  task automatic convert_once(input logic [2:0] code, input logic [2:0] prev, input bit mix);
    int n;
    int len;
    logic [NCH-1:0][RES-1:0] sa;
    logic signed [RES:0] s;
    os_code = code;
    pulse_convert();
    wait_busy(1'b1, n);
    check(n < 3000, 1'b1);
    if (mix) begin
      sa = samp;
      repeat (SC / 2) @(negedge i_clock);
      set_samples(18'h2b6d9);
      for (int c = 0; c < NCH; c++) begin
        s = ($signed({sa[c][RES-1], sa[c]}) + $signed({samp[c][RES-1], samp[c]})) >>> 1;
        exp_r[c] = s[RES-1:0];
      end
    end
    wait_busy(1'b0, len);
    len += mix ? SC / 2 : 0;
    n = ((prev == OS_INVALID) ? 1 : (1 << prev)) * SC;
    check(len >= n && len <= n + 1, 1'b1);
    @(negedge i_clock);
    check(dev_os, code);
    if (!mix) for (int c = 0; c < NCH; c++) exp_r[c] = samp[c];
  endtask : convert_once
  task automatic read_all(input logic d, input logic b, input logic p);
    int n;
    edges = 0;
    dual_sel = d;
    use_b = b;
    per_ch = p;
    @(negedge i_clock);
    rd = 1'b1;
    @(negedge i_clock);
    rd = 1'b0;
    check(h_reading, 1'b1);
    n = 0;
    while (h_valid !== 1'b1 && n < 3000) begin
      @(negedge i_clock);
      n++;
    end
    check(h_reading, 1'b0);
    check(edges, d ? 72 : 144);
    for (int c = 0; c < NCH; c++) check(h_result[c], exp_r[c]);
    check(h_first, 1'b1);
  endtask : read_all
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic sweep_ratios;
    logic [2:0] prev;
    prev = 3'h0;
    set_samples(18'h1c3a5);
    for (int i = 1; i <= NCH; i++) begin
      convert_once(3'(i), prev, 1'b0);
      prev = 3'(i);
    end
  endtask : sweep_ratios
  task automatic read_modes;
    for (int m = 0; m < 4; m++) begin
      set_samples(18'(m * 18'h0b1d3 + 18'h20010));
      convert_once(3'h0, 3'h0, 1'b0);
      read_all(m == 0, m == 2, m == 1);
    end
  endtask : read_modes
  task automatic average_mix;
    convert_once(3'h1, 3'h0, 1'b0);
    set_samples(18'h35e21);
    convert_once(3'h6, 3'h1, 1'b1);
    // a full 144-edge read leaves the link pointer back on V1
    read_all(1'b0, 1'b1, 1'b0);
  endtask : average_mix
  task automatic read_during_busy;
    int n;
    set_samples(18'h0f00d);
    pulse_convert();
    wait_busy(1'b1, n);
    read_all(1'b1, 1'b0, 1'b0);
    check(dev_busy, 1'b1);
    check(h_busy, 1'b1);
    wait_busy(1'b0, n);
    for (int c = 0; c < NCH; c++) exp_r[c] = samp[c];
    read_all(1'b0, 1'b0, 1'b0);
  endtask : read_during_busy
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clock);
    sweep_ratios();
    read_modes();
    average_mix();
    read_during_busy();
    report_and_stop();
  end
endmodule : adc_serial_readout_oversampling_tb_top
`default_nettype wire

/* File: bench/adcsr_properties.sv */
// concurrent checks on the serial readout link between both ends
`timescale 1ns/10ps
`default_nettype none
module adcsr_properties import adcsr_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sel,
  input wire logic ss_a,
  input wire logic ss_b,
  input wire logic [2:0] os,
  input wire logic busy,
  input wire logic dout_a_o,
  input wire logic dout_a_oe,
  input wire logic dout_b_o,
  input wire logic dout_b_oe,
  input wire logic frst_o,
  input wire logic frst_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // --------------------------------------------------------------------
  // link position tracking
  // --------------------------------------------------------------------
  logic sclk_q;
  logic step_w;
  logic [7:0] pos_q;
  logic [7:0] base_q;
  logic [7:0] frame_q;
  logic [7:0] off_w;
  logic [2:0] osl_q;
  logic [15:0] bcnt_q;
  int exp_w;
  assign step_w = !cs_n && sclk && !sclk_q;
  assign off_w = (pos_q >= base_q) ? pos_q - base_q : pos_q + 8'h90 - base_q;
  assign exp_w = ((osl_q == 3'h7) ? 1 : (1 << osl_q)) * SAMPLE_CYCLES;
  always_ff @(posedge i_clock) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pos_q <= 8'h00;
    end else if (step_w) begin
      pos_q <= (pos_q == 8'h8f) ? 8'h00 : pos_q + 8'h01;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst || cs_n) begin
      frame_q <= 8'h00;
    end else if (step_w) begin
      frame_q <= frame_q + 8'h01;
    end
  end
  // bank rotation and ratio latch both happen at busy fall
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      base_q <= 8'h00;
      osl_q <= 3'h0;
    end else if ($fell(busy)) begin
      base_q <= pos_q;
      osl_q <= os;
    end
  end
  always_ff @(posedge i_clock) begin
    bcnt_q <= (i_rst || !busy) ? 16'h0000 : bcnt_q + 16'h0001;
  end
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  sequence start_s;
    $rose(ss_a && ss_b) && !busy;
  endsequence
  sequence quiet_s;
    !cs_n && !$past(cs_n) && $stable(sclk) && $stable(busy);
  endsequence
  cs_release_a: assert property (cs_n |-> !dout_a_oe && !dout_b_oe)
    else $error("data lines driven while deselected");
  flag_tristate_a: assert property (cs_n |-> !frst_oe)
    else $error("first flag driven while deselected");
  select_drive_a: assert property (!cs_n && sel |-> dout_a_oe && dout_b_oe && frst_oe)
    else $error("outputs not driven while selected");
  bit_hold_a: assert property (quiet_s |-> $stable(dout_a_o) && $stable(dout_b_o))
    else $error("data bit changed without sclk rising");
  flag_value_a: assert property (frst_oe && $stable(sclk) && $stable(busy) |-> frst_o == (off_w < 8'h12))
    else $error("first flag wrong for word position");
  frame_whole_a: assert property ($rose(cs_n) |-> frame_q % 18 == 0)
    else $error("frame not whole words");
  start_busy_a: assert property (start_s |-> ##[1:8] busy)
    else $error("busy did not follow start");
  busy_len_a: assert property ($fell(busy) |-> bcnt_q >= exp_w && bcnt_q <= exp_w + 1)
    else $error("busy length wrong for ratio");
  start_pair_a: assert property (ss_a == ss_b)
    else $error("start inputs differ");
  sel_tied_a: assert property (sel)
    else $error("serial select not held high");
endmodule : adcsr_properties
`default_nettype wire

/* File: core/adcsr_device.sv */
// converter end: averaging conversion core and serial result readout
// What this block does
// - host ties interface select high for serial
// - V1-V4 on line a, V5-V8 on b
// - select fall drives MSB, leaves high impedance
// - remaining 17 bits shift on SCLK rising
// - select held or pulsed; 18 SCLK per result
// - both lines: eight results in 72 cycles
// - one line: 144 cycles, one or many frames
// - line b alone: V5..V8 then V1..V4
// - first flag: V1 on a, low after 18th
// - first flag never for V1 on b
// - reads during busy return previous results
// - ratio select three bits, bit 2 MSB
// - ratio latched at busy fall, next conversion
// - average samples, decimate to 18 bits
// - first sample at start, rest internal
// - host drives both start inputs together
// - busy lengthens with higher ratio
// - codes 0..6 give 1..64; 7 invalid
// - busy rises on start, falls at end
`timescale 1ns/10ps
`default_nettype none
module adcsr_device import adcsr_pkg::*; #(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  adcsr_link_if.dev lk,
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [NCH-1:0][RES-1:0] i_channel_sample,
  output logic [OS_W-1:0] o_os_applied,
  output logic o_busy
);
  localparam int SYNC_W = 8;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SAMPLE_CYCLES - 1);

  typedef enum logic {CV_IDLE, CV_RUN} adcsr_conv_e;

  logic [RES-1:0] bank_q [NCH];
  logic [NCH-1:0] first_q;
  logic [BIT_W-1:0] bit_q;
  logic [PTR_W-1:0] word_g_q;
  logic [PTR_W-1:0] word_a;
  logic [PTR_W-1:0] word_b;
  logic [BIT_W-1:0] bit_idx;
  logic active;

  // --------------------------------------------------------------------
  // link side, on the serial clock
  // --------------------------------------------------------------------
  assign active = !lk.cs_n && lk.sel;
  assign word_a = adcsr_bin(word_g_q);
  assign word_b = word_a + B_OFFSET;
  assign bit_idx = MSB_IDX - bit_q;

  // position survives select pulses; wraps after 144 edges
  always_ff @(posedge lk.sclk or posedge i_rst) begin
    if (i_rst) begin
      bit_q <= '0;
      word_g_q <= '0;
    end else if (active) begin
      if (bit_q == MSB_IDX) begin
        bit_q <= '0;
        word_g_q <= adcsr_gray(word_a + 3'h1);
      end else begin
        bit_q <= bit_q + 5'h01;
      end
    end
  end

  // bit 0 of the count shows the MSB as soon as select falls
  assign lk.dout_a_o = bank_q[word_a][bit_idx];
  assign lk.dout_b_o = bank_q[word_b][bit_idx];
  assign lk.dout_a_oe = active;
  assign lk.dout_b_oe = active;
  // flag follows the slot shown on line a only
  assign lk.frst_o = first_q[word_a];
  assign lk.frst_oe = active;

  // --------------------------------------------------------------------
  // crossing into the conversion clock
  // --------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sy1_q;
  logic [SYNC_W-1:0] sy2_q;
  logic [SYNC_W-1:0] sy3_q;
  logic [SYNC_W-1:0] filt_q;
  logic ss_a_lvl;
  logic ss_b_lvl;
  logic [OS_W-1:0] os_pin;
  logic [PTR_W-1:0] wptr;

  assign sync_in = {word_g_q, lk.os, lk.ss_b, lk.ss_a};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= sync_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // a change counts once the last two stages agree
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_filt
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          filt_q[g] <= 1'b0;
        end else if (sy2_q[g] == sy3_q[g]) begin
          filt_q[g] <= sy3_q[g];
        end
      end
    end
  endgenerate

  assign ss_a_lvl = filt_q[0];
  assign ss_b_lvl = filt_q[1];
  assign os_pin = filt_q[4:2];
  assign wptr = adcsr_bin(filt_q[7:5]);

  // --------------------------------------------------------------------
  // start detection
  // --------------------------------------------------------------------
  logic both_q;
  logic start;

  // later of the two rising edges starts the conversion
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      both_q <= 1'b0;
    end else begin
      both_q <= ss_a_lvl && ss_b_lvl;
    end
  end

  assign start = ss_a_lvl && ss_b_lvl && !both_q;

  // --------------------------------------------------------------------
  // conversion sequencing
  // --------------------------------------------------------------------
  adcsr_conv_e state_q;
  logic [TMR_W-1:0] tmr_q;
  logic [N_W-1:0] n_q;
  logic [OS_W-1:0] os_q;
  logic [OS_W-1:0] os_log;
  logic [N_W-1:0] n_target;
  logic tmr_done;
  logic take;
  logic finish;

  assign os_log = adcsr_os_log(os_q);
  assign n_target = N_W'(1) << os_log;
  assign tmr_done = (tmr_q == TMR_LAST);
  assign take = (state_q == CV_IDLE) ? start :
                (tmr_done && n_q != n_target);
  assign finish = (state_q == CV_RUN) && tmr_done && (n_q == n_target);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= CV_IDLE;
    end else begin
      case (state_q)
        CV_IDLE: begin
          if (start) begin
            state_q <= CV_RUN;
          end
        end
        CV_RUN: begin
          if (finish) begin
            state_q <= CV_IDLE;
          end
        end
        default: begin
          state_q <= CV_IDLE;
        end
      endcase
    end
  end

  // one conversion slot per sample, so busy grows with the ratio
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tmr_q <= '0;
      n_q <= '0;
    end else if (take) begin
      tmr_q <= '0;
      n_q <= (state_q == CV_IDLE) ? N_W'(1) : n_q + N_W'(1);
    end else if (state_q == CV_RUN && !tmr_done) begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  // ratio for the next conversion taken as busy falls
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      os_q <= OS_NONE;
    end else if (finish) begin
      os_q <= os_pin;
    end
  end

  // --------------------------------------------------------------------
  // averaging
  // --------------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_q [NCH];
  logic [RES-1:0] avg [NCH];

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int c = 0; c < NCH; c++) begin
        acc_q[c] <= '0;
      end
    end else if (take) begin
      for (int c = 0; c < NCH; c++) begin
        if (state_q == CV_IDLE) begin
          acc_q[c] <= ACC_W'($signed(i_channel_sample[c]));
        end else begin
          acc_q[c] <= acc_q[c] + ACC_W'($signed(i_channel_sample[c]));
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      avg[c] = RES'(acc_q[c] >>> os_log);
    end
  end

  // --------------------------------------------------------------------
  // output registers
  // --------------------------------------------------------------------
  // stored rotated so the slot the link points at next holds V1
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      first_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        bank_q[c] <= '0;
      end
    end else if (finish) begin
      for (int c = 0; c < NCH; c++) begin
        bank_q[PTR_W'(wptr + PTR_W'(c))] <= avg[c];
        first_q[PTR_W'(wptr + PTR_W'(c))] <= (c == 0);
      end
    end
  end

  assign lk.busy = (state_q == CV_RUN);
  assign o_busy = (state_q == CV_RUN);
  assign o_os_applied = os_q;
endmodule : adcsr_device
`default_nettype wire

/* File: core/adcsr_host.sv */
// serial master end: starts conversions and reads the eight results
`timescale 1ns/10ps
`default_nettype none
module adcsr_host import adcsr_pkg::*; #(
  parameter int HALF = SCLK_HALF
) (
  adcsr_link_if.host lk,
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_convert,
  input wire logic [OS_W-1:0] i_os_code,
  input wire logic i_read,
  input wire logic i_dual,
  input wire logic i_use_b,
  input wire logic i_cs_per_channel,
  output logic o_busy,
  output logic o_reading,
  output logic [NCH-1:0][RES-1:0] o_result,
  output logic o_result_valid,
  output logic o_first_seen
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_DONE} adcsr_host_e;
  localparam logic [3:0] HALF_LAST = 4'(HALF - 1);
  localparam logic [3:0] START_LAST = 4'(START_CYC - 1);

  // --------------------------------------------------------------------
  // pin input synchronisers
  // --------------------------------------------------------------------
  logic [3:0] pin_in;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;

  assign pin_in = {lk.busy, lk.frst, lk.dout_b, lk.dout_a};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          pin_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          pin_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign o_busy = pin_q[3];

  // --------------------------------------------------------------------
  // conversion start
  // --------------------------------------------------------------------
  logic ss_q;
  logic [3:0] ss_cnt_q;

  // one signal drives both start inputs
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ss_q <= 1'b0;
      ss_cnt_q <= '0;
    end else if (!ss_q && i_convert) begin
      ss_q <= 1'b1;
      ss_cnt_q <= '0;
    end else if (ss_q) begin
      ss_q <= (ss_cnt_q != START_LAST);
      ss_cnt_q <= ss_cnt_q + 4'h1;
    end
  end

  assign lk.ss_a = ss_q;
  assign lk.ss_b = ss_q;
  assign lk.os = i_os_code;
  assign lk.sel = 1'b1;

  // --------------------------------------------------------------------
  // readout sequencer
  // --------------------------------------------------------------------
  adcsr_host_e st_q;
  logic [3:0] ph_q;
  logic [BIT_W-1:0] bit_q;
  logic [PTR_W-1:0] word_q;
  logic [RES-1:0] sh_a_q;
  logic [RES-1:0] sh_b_q;
  logic dual_q;
  logic use_b_q;
  logic per_q;
  logic ph_end;
  logic last_word;

  assign ph_end = (ph_q == HALF_LAST);
  assign last_word = dual_q ? (word_q == PTR_W'(WORDS_DUAL - 1)) :
                              (word_q == PTR_W'(WORDS_SINGLE - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= H_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      word_q <= '0;
      dual_q <= 1'b0;
      use_b_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      ph_q <= (st_q == H_IDLE || ph_end) ? 4'h0 : ph_q + 4'h1;
      case (st_q)
        H_IDLE: begin
          if (i_read) begin
            st_q <= H_SETUP;
            bit_q <= '0;
            word_q <= '0;
            dual_q <= i_dual;
            use_b_q <= i_use_b;
            per_q <= i_cs_per_channel;
          end
        end
        H_SETUP: begin
          if (ph_end) begin
            st_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (ph_end) begin
            st_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (ph_end) begin
            if (bit_q != MSB_IDX) begin
              bit_q <= bit_q + 5'h01;
              st_q <= H_LOW;
            end else begin
              bit_q <= '0;
              word_q <= word_q + 3'h1;
              st_q <= last_word ? H_DONE : (per_q ? H_GAP : H_LOW);
            end
          end
        end
        H_GAP: begin
          if (ph_end) begin
            st_q <= H_SETUP;
          end
        end
        H_DONE: begin
          st_q <= H_IDLE;
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // sclk idles high; data taken at the end of each low phase
  assign lk.sclk = (st_q != H_LOW);
  assign lk.cs_n = (st_q == H_IDLE || st_q == H_GAP || st_q == H_DONE);
  assign o_reading = !lk.cs_n;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sh_a_q <= '0;
      sh_b_q <= '0;
    end else if (st_q == H_LOW && ph_end) begin
      sh_a_q <= {sh_a_q[RES-2:0], pin_q[0]};
      sh_b_q <= {sh_b_q[RES-2:0], pin_q[1]};
    end
  end

  // --------------------------------------------------------------------
  // result store
  // --------------------------------------------------------------------
  logic word_end;

  assign word_end = (st_q == H_HIGH) && ph_end && (bit_q == MSB_IDX);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_result <= '0;
    end else if (word_end) begin
      if (dual_q) begin
        o_result[word_q] <= sh_a_q;
        o_result[word_q + B_OFFSET] <= sh_b_q;
      end else if (use_b_q) begin
        o_result[word_q + B_OFFSET] <= sh_b_q;
      end else begin
        o_result[word_q] <= sh_a_q;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_first_seen <= 1'b0;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= (st_q == H_DONE);
      if (st_q == H_IDLE && i_read) begin
        o_first_seen <= 1'b0;
      end else if (st_q == H_LOW && ph_end && word_q == '0 && pin_q[2]) begin
        o_first_seen <= 1'b1;
      end
    end
  end
endmodule : adcsr_host
`default_nettype wire

/* File: core/adcsr_link_if.sv */
// pins between the converter readout and its serial master
`timescale 1ns/10ps
`default_nettype none
interface adcsr_link_if;
  logic sclk;
  logic cs_n;
  logic sel;
  logic ss_a;
  logic ss_b;
  logic [2:0] os;
  logic busy;
  logic dout_a_o;
  logic dout_a_oe;
  logic dout_b_o;
  logic dout_b_oe;
  logic frst_o;
  logic frst_oe;
  logic dout_a;
  logic dout_b;
  logic frst;
  // undriven lines read low
  assign dout_a = dout_a_oe & dout_a_o;
  assign dout_b = dout_b_oe & dout_b_o;
  assign frst = frst_oe & frst_o;
  modport dev (
    input sclk, cs_n, sel, ss_a, ss_b, os,
    output busy, dout_a_o, dout_a_oe, dout_b_o, dout_b_oe, frst_o, frst_oe
  );
  modport host (
    output sclk, cs_n, sel, ss_a, ss_b, os,
    input busy, dout_a, dout_b, frst, dout_a_oe, dout_b_oe, frst_oe
  );
endinterface : adcsr_link_if
`default_nettype wire

/* File: core/adcsr_pkg.sv */
// constants and helpers shared by both ends of the serial readout link
package adcsr_pkg;
  // --------------------------------------------------------------------
  // data shape
  // --------------------------------------------------------------------
  localparam int NCH = 8;
  localparam int RES = 18;
  localparam int BIT_W = 5;
  localparam int PTR_W = 3;
  localparam int OS_W = 3;
  localparam int OS_MAX_LOG = 6;
  localparam int ACC_W = RES + OS_MAX_LOG;
  localparam int N_W = OS_MAX_LOG + 1;
  localparam logic [OS_W-1:0] OS_NONE = 3'h0;
  localparam logic [OS_W-1:0] OS_INVALID = 3'h7;
  localparam logic [PTR_W-1:0] B_OFFSET = 3'h4;
  localparam logic [BIT_W-1:0] MSB_IDX = 5'h11;
  localparam int WORDS_DUAL = 4;
  localparam int WORDS_SINGLE = 8;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_SAMPLE_NS = 4000;
  localparam int SAMPLE_CYC = (T_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_START_NS = 50;
  localparam int START_CYC = (T_START_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF = 4;
  localparam int TMR_W = 12;
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [PTR_W-1:0] adcsr_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : adcsr_gray

  function automatic logic [PTR_W-1:0] adcsr_bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[2] = g[2];
    b[1] = g[2] ^ g[1];
    b[0] = b[1] ^ g[0];
    return b;
  endfunction : adcsr_bin

  // invalid code falls back to no averaging
  function automatic logic [OS_W-1:0] adcsr_os_log(input logic [OS_W-1:0] c);
    return (c == OS_INVALID) ? OS_NONE : c;
  endfunction : adcsr_os_log
endpackage : adcsr_pkg
